// File: rtl/ulfc_consts.vh
/*
 Constants for the line format control block: register offsets, field
 positions, reset values and framing figures.
 Assumes inclusion by bare name from files under rtl/.
*/
`ifndef ULFC_CONSTS_VH
`define ULFC_CONSTS_VH

`define ULFC_ADDR_W 4
`define ULFC_OFF_DATA 4'h0
`define ULFC_OFF_DIV_LO 4'h0
`define ULFC_OFF_DIV_HI 4'h1
`define ULFC_OFF_EFR 4'h2
`define ULFC_OFF_LFC 4'h3
`define ULFC_OFF_STATUS 4'h5
`define ULFC_OFF_RXDATA 4'h6

`define ULFC_LFC_RESET 8'h00
`define ULFC_DIV_RESET 16'h0001
`define ULFC_EFR_RESET 8'h00

`define ULFC_BIT_DLAB 7
`define ULFC_BIT_BREAK 6
`define ULFC_BIT_STICK 5
`define ULFC_BIT_EVEN 4
`define ULFC_BIT_PEN 3
`define ULFC_BIT_STOP 2
`define ULFC_BIT_WLEN_HI 1
`define ULFC_BIT_WLEN_LO 0

`define ULFC_OVS 16
`define ULFC_HALF_OVS 8

`define ULFC_ST_BUSY 0
`define ULFC_ST_RXRDY 1
`define ULFC_ST_PERR 2
`define ULFC_ST_FERR 3

`endif

// File: rtl/ulfc_framer.v
/*
 Serial framer: one transmit and one receive character engine driven by the
 decoded format and a 16x oversampling tick.
 Assumes rx_sync is already synchronised to clk_sys.
*/
`timescale 1ns/1ps
`include "ulfc_consts.vh"

module ulfc_framer (
    // Clock and reset
    input wire clk_sys,
    input wire resetn,
    // Format
    input wire [3:0] data_bits,
    input wire par_en,
    input wire par_stick,
    input wire par_even,
    input wire stop_long,
    input wire brk,
    input wire tick,
    // Transmit request
    input wire tx_start,
    input wire [7:0] tx_data,
    output wire tx_busy,
    output reg tx_ff,
    // Receive
    input wire rx_sync,
    output reg rx_done_ff,
    output reg [7:0] rx_data_ff,
    output reg rx_perr_ff,
    output reg rx_ferr_ff
);
    localparam S_IDLE = 2'd0;
    localparam S_START = 2'd1;
    localparam S_DATA = 2'd2;
    localparam S_PAR = 2'd3;

    reg [1:0] tx_st_ff;
    reg tx_stop_ff;
    reg [3:0] tx_cnt_ff;
    reg [3:0] tx_bit_ff;
    reg [5:0] tx_stop_cnt_ff;
    reg [7:0] tx_sh_ff;
    reg tx_par_ff;
    reg [1:0] rx_st_ff;
    reg rx_stop_ff;
    reg [3:0] rx_cnt_ff;
    reg [3:0] rx_bit_ff;
    reg [7:0] rx_sh_ff;
    reg rx_par_ff;
    wire [5:0] stop_ticks;
    wire par_fixed;
    wire tx_line;

    assign stop_ticks = !stop_long ? 6'd16 : (data_bits == 4'd5 ? 6'd24 : 6'd32);
    assign par_fixed = ~par_even;
    assign tx_busy = (tx_st_ff != S_IDLE) || tx_stop_ff;
    assign tx_line = (tx_st_ff == S_START) ? 1'b0 :
                     (tx_st_ff == S_DATA) ? tx_sh_ff[0] :
                     (tx_st_ff == S_PAR) ? tx_par_ff : 1'b1;

    always @(posedge clk_sys) begin
        if (!resetn) begin
            tx_st_ff <= S_IDLE;
            tx_stop_ff <= 1'b0;
            tx_cnt_ff <= 4'h0;
            tx_bit_ff <= 4'h0;
            tx_stop_cnt_ff <= 6'h00;
            tx_sh_ff <= 8'h00;
            tx_par_ff <= 1'b0;
            tx_ff <= 1'b1;
        end else begin
            tx_ff <= brk ? 1'b0 : tx_line;
            if (tx_stop_ff) begin
                if (tick) begin
                    if (tx_stop_cnt_ff == stop_ticks - 6'd1) begin
                        tx_stop_ff <= 1'b0;
                        tx_stop_cnt_ff <= 6'h00;
                    end else begin
                        tx_stop_cnt_ff <= tx_stop_cnt_ff + 6'd1;
                    end
                end
            end else begin
                case (tx_st_ff)
                    S_IDLE: begin
                        if (tx_start) begin
                            tx_st_ff <= S_START;
                            tx_sh_ff <= tx_data;
                            tx_cnt_ff <= 4'h0;
                            tx_bit_ff <= 4'h0;
                            tx_par_ff <= par_stick ? par_fixed : ~par_even;
                        end
                    end
                    S_START: begin
                        if (tick) begin
                            tx_cnt_ff <= tx_cnt_ff + 4'd1;
                            if (tx_cnt_ff == 4'hf) begin
                                tx_st_ff <= S_DATA;
                            end
                        end
                    end
                    S_DATA: begin
                        if (tick) begin
                            tx_cnt_ff <= tx_cnt_ff + 4'd1;
                            if (tx_cnt_ff == 4'hf) begin
                                if (!par_stick) begin
                                    tx_par_ff <= tx_par_ff ^ tx_sh_ff[0];
                                end
                                tx_sh_ff <= {1'b0, tx_sh_ff[7:1]};
                                tx_bit_ff <= tx_bit_ff + 4'd1;
                                if (tx_bit_ff == data_bits - 4'd1) begin
                                    if (par_en) begin
                                        tx_st_ff <= S_PAR;
                                    end else begin
                                        tx_st_ff <= S_IDLE;
                                        tx_stop_ff <= 1'b1;
                                    end
                                end
                            end
                        end
                    end
                    S_PAR: begin
                        if (tick) begin
                            tx_cnt_ff <= tx_cnt_ff + 4'd1;
                            if (tx_cnt_ff == 4'hf) begin
                                tx_st_ff <= S_IDLE;
                                tx_stop_ff <= 1'b1;
                            end
                        end
                    end
                    default: tx_st_ff <= S_IDLE;
                endcase
            end
        end
    end

    always @(posedge clk_sys) begin
        if (!resetn) begin
            rx_st_ff <= S_IDLE;
            rx_stop_ff <= 1'b0;
            rx_cnt_ff <= 4'h0;
            rx_bit_ff <= 4'h0;
            rx_sh_ff <= 8'h00;
            rx_par_ff <= 1'b0;
            rx_done_ff <= 1'b0;
            rx_data_ff <= 8'h00;
            rx_perr_ff <= 1'b0;
            rx_ferr_ff <= 1'b0;
        end else begin
            rx_done_ff <= 1'b0;
            if (rx_stop_ff) begin
                if (tick) begin
                    rx_cnt_ff <= rx_cnt_ff + 4'd1;
                    if (rx_cnt_ff == 4'hf) begin
                        rx_stop_ff <= 1'b0;
                        rx_done_ff <= 1'b1;
                        rx_data_ff <= rx_sh_ff >> (4'd8 - data_bits);
                        rx_ferr_ff <= ~rx_sync;
                        rx_perr_ff <= par_en & (par_stick ? (rx_par_ff != par_fixed) :
                                                 (rx_par_ff != ~par_even));
                    end
                end
            end else begin
                case (rx_st_ff)
                    S_IDLE: begin
                        rx_cnt_ff <= 4'h0;
                        rx_bit_ff <= 4'h0;
                        rx_par_ff <= 1'b0;
                        if (!rx_sync) begin
                            rx_st_ff <= S_START;
                        end
                    end
                    S_START: begin
                        if (tick) begin
                            rx_cnt_ff <= rx_cnt_ff + 4'd1;
                            if (rx_cnt_ff == `ULFC_HALF_OVS - 1) begin
                                rx_cnt_ff <= 4'h0;
                                rx_st_ff <= rx_sync ? S_IDLE : S_DATA;
                            end
                        end
                    end
                    S_DATA: begin
                        if (tick) begin
                            rx_cnt_ff <= rx_cnt_ff + 4'd1;
                            if (rx_cnt_ff == 4'hf) begin
                                rx_sh_ff <= {rx_sync, rx_sh_ff[7:1]};
                                rx_par_ff <= rx_par_ff ^ rx_sync;
                                rx_bit_ff <= rx_bit_ff + 4'd1;
                                if (rx_bit_ff == data_bits - 4'd1) begin
                                    if (par_en) begin
                                        rx_st_ff <= S_PAR;
                                    end else begin
                                        rx_st_ff <= S_IDLE;
                                        rx_stop_ff <= 1'b1;
                                    end
                                end
                            end
                        end
                    end
                    S_PAR: begin
                        if (tick) begin
                            rx_cnt_ff <= rx_cnt_ff + 4'd1;
                            if (rx_cnt_ff == 4'hf) begin
                                // Stick mode compares the raw bit, else the running parity
                                rx_par_ff <= par_stick ? rx_sync : (rx_par_ff ^ rx_sync);
                                rx_st_ff <= S_IDLE;
                                rx_stop_ff <= 1'b1;
                            end
                        end
                    end
                    default: rx_st_ff <= S_IDLE;
                endcase
            end
        end
    end
endmodule

// File: rtl/ulfc_top.v
/*
 Line format control for one serial channel: the format register, the
 divisor latch and enhanced feature register behind the access gate, a
 baud tick and the framer.
 Assumes a single-cycle register port master on clk_sys and an
 asynchronous serial line on rx_pin.
*/
// Notes on behaviour
// - Bit 7 switches access to divisor, feature register
// - Bit 6 holds serial output low
// - Bit 3 enables parity send and check
// - Bit 4 picks even, else odd parity
// - Bit 5 forces parity to inverse of bit 4
// - Bit 2 gives 1.5 or 2 stop bits
// - Bits 1:0 give 5 to 8 data bits
// - Format register resets to all zero
`timescale 1ns/1ps
`include "ulfc_consts.vh"

module ulfc_top (
    // Clock and reset
    input wire clk_sys,
    input wire resetn,
    // Register port
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata_ff,
    // Serial line
    input wire rx_pin,
    output wire tx_pin
);
    reg [7:0] line_format_control_ff;
    reg [15:0] div_ff;
    reg [7:0] efr_ff;
    reg [15:0] baud_cnt_ff;
    reg tick_ff;
    reg rx_meta_ff;
    reg rx_sync_ff;
    reg tx_go_ff;
    reg [7:0] tx_hold_ff;
    reg rx_ready_ff;
    reg [7:0] rx_buf_ff;
    reg perr_ff;
    reg ferr_ff;
    reg [7:0] nxt_rdata;
    wire dlab;
    wire tx_busy;
    wire rx_done;
    wire [7:0] rx_data;
    wire rx_perr;
    wire rx_ferr;
    wire [3:0] data_bits;

    assign dlab = line_format_control_ff[`ULFC_BIT_DLAB];
    assign data_bits = 4'd5 + {2'b00, line_format_control_ff[`ULFC_BIT_WLEN_HI:`ULFC_BIT_WLEN_LO]};

    // Format, divisor and feature registers
    always @(posedge clk_sys) begin
        if (!resetn) begin
            line_format_control_ff <= `ULFC_LFC_RESET;
            div_ff <= `ULFC_DIV_RESET;
            efr_ff <= `ULFC_EFR_RESET;
            tx_go_ff <= 1'b0;
            tx_hold_ff <= 8'h00;
        end else begin
            tx_go_ff <= 1'b0;
            if (reg_wr) begin
                case (reg_addr)
                    `ULFC_OFF_LFC: line_format_control_ff <= reg_wdata;
                    `ULFC_OFF_DIV_LO: begin
                        if (dlab) begin
                            div_ff[7:0] <= reg_wdata;
                        end else if (!tx_busy) begin
                            tx_hold_ff <= reg_wdata;
                            tx_go_ff <= 1'b1;
                        end
                    end
                    `ULFC_OFF_DIV_HI: begin
                        if (dlab) begin
                            div_ff[15:8] <= reg_wdata;
                        end
                    end
                    `ULFC_OFF_EFR: begin
                        if (dlab) begin
                            efr_ff <= reg_wdata;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // Receive holding and status, set wins over a read clear
    always @(posedge clk_sys) begin
        if (!resetn) begin
            rx_ready_ff <= 1'b0;
            rx_buf_ff <= 8'h00;
            perr_ff <= 1'b0;
            ferr_ff <= 1'b0;
        end else begin
            if (rx_done) begin
                rx_ready_ff <= 1'b1;
                rx_buf_ff <= rx_data;
                perr_ff <= rx_perr;
                ferr_ff <= rx_ferr;
            end else if (reg_rd && !dlab && reg_addr == `ULFC_OFF_RXDATA) begin
                rx_ready_ff <= 1'b0;
                perr_ff <= 1'b0;
                ferr_ff <= 1'b0;
            end
        end
    end

    // Read data, one cycle after the strobe
    always @* begin
        nxt_rdata = 8'h00;
        case (reg_addr)
            `ULFC_OFF_LFC: nxt_rdata = line_format_control_ff;
            `ULFC_OFF_DIV_LO: nxt_rdata = dlab ? div_ff[7:0] : 8'h00;
            `ULFC_OFF_DIV_HI: nxt_rdata = dlab ? div_ff[15:8] : 8'h00;
            `ULFC_OFF_EFR: nxt_rdata = dlab ? efr_ff : 8'h00;
            `ULFC_OFF_STATUS: begin
                nxt_rdata[`ULFC_ST_BUSY] = tx_busy;
                nxt_rdata[`ULFC_ST_RXRDY] = rx_ready_ff;
                nxt_rdata[`ULFC_ST_PERR] = perr_ff;
                nxt_rdata[`ULFC_ST_FERR] = ferr_ff;
            end
            `ULFC_OFF_RXDATA: nxt_rdata = dlab ? 8'h00 : rx_buf_ff;
            default: nxt_rdata = 8'h00;
        endcase
    end

    always @(posedge clk_sys) begin
        if (!resetn) begin
            reg_rdata_ff <= 8'h00;
        end else begin
            reg_rdata_ff <= reg_rd ? nxt_rdata : 8'h00;
        end
    end

    // Oversampling tick from the divisor
    always @(posedge clk_sys) begin
        if (!resetn) begin
            baud_cnt_ff <= 16'h0000;
            tick_ff <= 1'b0;
        end else begin
            if (baud_cnt_ff + 16'd1 >= div_ff) begin
                baud_cnt_ff <= 16'h0000;
                tick_ff <= 1'b1;
            end else begin
                baud_cnt_ff <= baud_cnt_ff + 16'd1;
                tick_ff <= 1'b0;
            end
        end
    end

    // Line input synchroniser
    always @(posedge clk_sys) begin
        if (!resetn) begin
            rx_meta_ff <= 1'b1;
            rx_sync_ff <= 1'b1;
        end else begin
            rx_meta_ff <= rx_pin;
            rx_sync_ff <= rx_meta_ff;
        end
    end

    ulfc_framer u_framer (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .data_bits(data_bits),
        .par_en(line_format_control_ff[`ULFC_BIT_PEN]),
        .par_stick(line_format_control_ff[`ULFC_BIT_STICK]),
        .par_even(line_format_control_ff[`ULFC_BIT_EVEN]),
        .stop_long(line_format_control_ff[`ULFC_BIT_STOP]),
        .brk(line_format_control_ff[`ULFC_BIT_BREAK]),
        .tick(tick_ff),
        .tx_start(tx_go_ff),
        .tx_data(tx_hold_ff),
        .tx_busy(tx_busy),
        .tx_ff(tx_pin),
        .rx_sync(rx_sync_ff),
        .rx_done_ff(rx_done),
        .rx_data_ff(rx_data),
        .rx_perr_ff(rx_perr),
        .rx_ferr_ff(rx_ferr)
    );
endmodule

// File: tb/ulfc_checker.sv
/*
 Port checker for the line format control top.
 Assumes one clock, synchronous active-low reset, no writes during reset.
*/
`timescale 1ns/1ps
module ulfc_checker (
    // Clock and reset
    input wire clk_sys,
    input wire resetn,
    // Register port
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata_ff,
    // Serial line
    input wire rx_pin,
    input wire tx_pin
);
    reg [7:0] fmt_ff;
    wire [7:0] nxt_fmt = (reg_wr && reg_addr == 4'h3) ? reg_wdata : fmt_ff;

    // Shadow of the format register
    always @(posedge clk_sys) begin
        if (!resetn) begin
            fmt_ff <= 8'h00;
        end else begin
            fmt_ff <= nxt_fmt;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    chk_reset_idle: assert property ($rose(resetn) |-> tx_pin && reg_rdata_ff == 8'h00)
        else $error("line not idle after reset");
    chk_rdata_idle: assert property (!reg_rd |=> reg_rdata_ff == 8'h00)
        else $error("read data outside read slot");
    chk_fmt_readback: assert property (reg_rd && reg_addr == 4'h3 |=> reg_rdata_ff == $past(fmt_ff))
        else $error("format register readback wrong");
    chk_unmapped_read: assert property (reg_rd && reg_addr == 4'hF |=> reg_rdata_ff == 8'h00)
        else $error("unmapped read not zero");
    chk_gate_closed: assert property (reg_rd && !fmt_ff[7] && (reg_addr == 4'h1 || reg_addr == 4'h2)
        |=> reg_rdata_ff == 8'h00)
        else $error("divisor visible with gate closed");
    chk_break_low: assert property (fmt_ff[6] && $past(fmt_ff[6]) |-> !tx_pin)
        else $error("break not holding line low");
    chk_start_low: assert property ($fell(tx_pin) && !fmt_ff[6] |-> (!tx_pin) [*8])
        else $error("low bit shorter than half a bit");
    chk_mark_high: assert property ($rose(tx_pin) && !fmt_ff[6] && !$past(fmt_ff[6]) |-> tx_pin [*8])
        else $error("high bit shorter than half a bit");

    cov_break: cover property (fmt_ff[6] && !tx_pin);
    cov_parity_frame: cover property ($fell(tx_pin) && fmt_ff[3]);
    cov_gate_read: cover property (reg_rd && fmt_ff[7] && reg_addr == 4'h2);
endmodule

bind ulfc_top ulfc_checker u_chk (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .rx_pin(rx_pin), .tx_pin(tx_pin));

// File: tb/ulfc_remote.sv
/*
 Remote serial device: sends framed characters and samples received ones.
 Assumes divisor 1, so one bit lasts 16 clocks; line idles high.
*/
`timescale 1ns/1ps
module ulfc_remote (
    // Clock
    input wire clk_sys,
    // Serial line
    output logic rx_line,
    input wire tx_line
);
    initial rx_line = 1'b1;

    function automatic logic par_of(input logic [7:0] fmt, input logic [7:0] d);
        logic [7:0] m;
        m = d & (8'hFF >> (3 - fmt[1:0]));
        if (fmt[5]) return ~fmt[4];
        return fmt[4] ? ^m : ~^m;
    endfunction

    // Frame with start, data LSB first, optional parity, two stop bits
    task automatic send_char(input logic [7:0] fmt, input logic [7:0] d, input logic bad);
        integer i;
        rx_line <= 1'b0;
        repeat (16) @(posedge clk_sys);
        for (i = 0; i < 5 + fmt[1:0]; i++) begin
            rx_line <= d[i];
            repeat (16) @(posedge clk_sys);
        end
        if (fmt[3]) begin
            rx_line <= par_of(fmt, d) ^ bad;
            repeat (16) @(posedge clk_sys);
        end
        rx_line <= 1'b1;
        repeat (32) @(posedge clk_sys);
    endtask

    // Samples each bit in its middle
    task automatic get_char(input logic [7:0] fmt, output logic [7:0] d, output logic p);
        integer i;
        integer t;
        d = 8'h00;
        p = 1'b0;
        t = 0;
        while (tx_line && t < 2000) begin
            @(posedge clk_sys);
            t++;
        end
        repeat (8) @(posedge clk_sys);
        for (i = 0; i < 5 + fmt[1:0]; i++) begin
            repeat (16) @(posedge clk_sys);
            d[i] = tx_line;
        end
        if (fmt[3]) begin
            repeat (16) @(posedge clk_sys);
            p = tx_line;
        end
    endtask
endmodule

// File: tb/tb.sv
/*
 Self-checking bench for the line format control top.
 Assumes offsets 0 data/div-lo, 1 div-hi, 2 feature, 3 format, 5 status, 6 rx.
*/
`timescale 1ns/1ps
module tb;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    wire [7:0] reg_rdata_ff;
    wire rx_pin;
    wire tx_pin;
    integer err_count = 0;
    integer cmp_count = 0;
    logic [7:0] rows [8] = '{8'h00, 8'h04, 8'h05, 8'h0A, 8'h1B, 8'h2B, 8'h3F, 8'h33};
    logic [7:0] fmt, d, mask, s;
    logic p;
    integer i, t, frame;

    ulfc_top dut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .rx_pin(rx_pin), .tx_pin(tx_pin));
    ulfc_remote rem (.clk_sys(clk_sys), .rx_line(rx_pin), .tx_line(tx_pin));

    initial forever #2 clk_sys = ~clk_sys;

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 v = reg_rdata_ff;
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge clk_sys);
        resetn <= 1'b1;
        rd(4'h3, s);
        chk("format reset", s, 8'h00);
        rd(4'hF, s);
        chk("unmapped read", s, 8'h00);
        $display("test reset done");
        for (i = 0; i < 8; i++) begin
            fmt = rows[i];
            mask = 8'hFF >> (3 - fmt[1:0]);
            wr(4'h3, fmt);
            rd(4'h3, s);
            chk("format readback", s, fmt);
            wr(4'h0, 8'hA6 + i[7:0]);
            frame = (1 + 5 + fmt[1:0] + fmt[3]) * 16 + (!fmt[2] ? 16 : (fmt[1:0] == 2'b00 ? 24 : 32));
            t = 0;
            fork
                rem.get_char(fmt, d, p);
                begin
                    s = 8'h01;
                    while (s[0] && t < 1000) begin
                        rd(4'h5, s);
                        t += 2;
                    end
                end
            join
            if (t >= 1000) begin
                err_count++;
                finish_test();
            end
            chk("tx data", d, (8'hA6 + i[7:0]) & mask);
            chk("tx parity", {7'h00, p}, fmt[3] ? {7'h00, rem.par_of(fmt, 8'hA6 + i[7:0])} : 8'h00);
            chk("frame length ok", {7'h00, t >= frame - 2 && t <= frame + 5}, 8'h01);
            rem.send_char(fmt, 8'h59 ^ i[7:0], 1'b0);
            rd(4'h5, s);
            chk("rx status", s & 8'h0E, 8'h02);
            rd(4'h6, s);
            chk("rx data", s, (8'h59 ^ i[7:0]) & mask);
            $display("test format %h done", fmt);
        end
        wr(4'h3, 8'h1B);
        rem.send_char(8'h1B, 8'hC3, 1'b1);
        rd(4'h5, s);
        chk("parity error flag", s & 8'h04, 8'h04);
        rd(4'h6, s);
        $display("test parity error done");
        wr(4'h3, 8'h40);
        repeat (2) @(posedge clk_sys);
        chk("break line", {7'h00, tx_pin}, 8'h00);
        wr(4'h3, 8'h00);
        repeat (2) @(posedge clk_sys);
        chk("break release", {7'h00, tx_pin}, 8'h01);
        $display("test break done");
        wr(4'h1, 8'h77);
        wr(4'h3, 8'h80);
        rd(4'h1, s);
        chk("div hi write ignored", s, 8'h00);
        wr(4'h2, 8'h5A);
        wr(4'h0, 8'h01);
        rd(4'h2, s);
        chk("feature reg", s, 8'h5A);
        rd(4'h0, s);
        chk("div lo", s, 8'h01);
        chk("no tx with gate", {7'h00, tx_pin}, 8'h01);
        wr(4'h3, 8'h00);
        rd(4'h2, s);
        chk("gate closed", s, 8'h00);
        $display("test gate done");
        finish_test();
    end
endmodule
